/* File: core/skip_flag_pkg.sv */
// shared constants and types for the flag-skip instruction block
package skip_flag_pkg;

    localparam int OPC_W    = 10;
    localparam int ADDR_W   = 3;
    localparam int DATA_W   = 8;
    localparam int NUM_SRC  = 3;

    // opcodes, index order: serial, timer 1, timer 2
    localparam logic [OPC_W-1:0] OPC_SKIP_SERIAL = 10'h288;
    localparam logic [OPC_W-1:0] OPC_SKIP_TIMER1 = 10'h280;
    localparam logic [OPC_W-1:0] OPC_SKIP_TIMER2 = 10'h281;

    // source indices
    localparam int SRC_SERIAL = 0;
    localparam int SRC_TIMER1 = 1;
    localparam int SRC_TIMER2 = 2;

    // control bit positions inside the interrupt control registers
    localparam int SERIAL_CTRL_POS = 3;
    localparam int TIMER1_CTRL_POS = 2;
    localparam int TIMER2_CTRL_POS = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS    = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 3'h4;

    // reset values
    localparam logic [3:0]         CTRL_RESET   = 4'h0;
    localparam logic [NUM_SRC-1:0] STATUS_RESET = 3'h0;
    localparam logic [NUM_SRC-1:0] MASK_RESET   = 3'h0;

    typedef struct packed {
        logic             valid;
        logic [OPC_W-1:0] opcode;
    } instr_t;

    // one bit per request source, serial in bit 0
    typedef struct packed {
        logic timer2;
        logic timer1;
        logic serial;
    } src_vec_t;

    typedef enum logic {
        SEQ_RUN,
        SEQ_SKIP
    } seq_state_t;

endpackage

/* File: core/request_flag_cell.sv */
// one interrupt request flag: set by its peripheral, cleared by a skip
`timescale 1ns/1ps
module request_flag_cell (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);

    logic flag_q;

    // a request landing in the clearing cycle survives
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= set_in | (flag_q & ~clear_in);
        end
    end

    assign flag_out = flag_q;

endmodule

/* File: core/skip_flag_decoder.sv */
// flag-test skip instructions: decode, skip sequencing, request flags
//
// Summary of operation
// - serial skip opcode 1010001000, one word, one cycle, carry untouched
// - serial control bit 0 and serial flag set: skip the next word
// - serial skip clears the serial flag; flag 0 means no skip
// - serial control bit 1: instruction is a pure no-operation
// - timer 1 skip opcode 1010000000, one word, one cycle, carry untouched
// - timer 1 control bit 0 and timer 1 flag set: skip next word
// - timer 1 skip clears the timer 1 flag; flag 0 means no skip
// - timer 1 control bit 1: instruction is a no-operation
// - timer 2 skip opcode 1010000001, skips on control 0 and flag set
// - timer 2 control is bit 3 of register one; clears flag or no-ops
`timescale 1ns/1ps
module skip_flag_decoder (
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_n_in,
    input  wire skip_flag_pkg::instr_t                instr_in,
    input  wire skip_flag_pkg::src_vec_t              request_set_in,
    input  wire logic [skip_flag_pkg::ADDR_W-1:0]     addr_in,
    input  wire logic [skip_flag_pkg::DATA_W-1:0]     wdata_in,
    input  wire logic                                 wr_in,
    input  wire logic                                 rd_in,
    output logic [skip_flag_pkg::DATA_W-1:0]          rdata_out,
    output skip_flag_pkg::src_vec_t                   flags_out,
    output logic                                      skip_next_out,
    output logic                                      carry_hold_out,
    output logic                                      irq_out
);
    import skip_flag_pkg::*;

    localparam logic [NUM_SRC-1:0][OPC_W-1:0] OPCODES =
        {OPC_SKIP_TIMER2, OPC_SKIP_TIMER1, OPC_SKIP_SERIAL};

    logic [3:0]          ctrl_one_q;
    logic [3:0]          ctrl_two_q;
    logic [NUM_SRC-1:0]  status_q;
    logic [NUM_SRC-1:0]  mask_q;
    logic [DATA_W-1:0]   rdata_q;
    seq_state_t          state_q;
    logic                skip_next_q;
    logic                carry_hold_q;
    logic                irq_q;
    logic [NUM_SRC-1:0]  flag_vec;
    logic [NUM_SRC-1:0]  set_vec;
    logic [NUM_SRC-1:0]  ctrl_vec;
    logic [NUM_SRC-1:0]  hit_vec;
    logic [NUM_SRC-1:0]  take_vec;
    logic                exec_now;
    logic                any_take;

    assign set_vec = request_set_in;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_flag
            request_flag_cell u_flag (
                .clk_in   (clk_in),
                .rst_n_in (rst_n_in),
                .set_in   (set_vec[g]),
                .clear_in (take_vec[g]),
                .flag_out (flag_vec[g])
            );
        end
    endgenerate

    assign ctrl_vec[SRC_SERIAL] = ctrl_two_q[SERIAL_CTRL_POS];
    assign ctrl_vec[SRC_TIMER1] = ctrl_one_q[TIMER1_CTRL_POS];
    assign ctrl_vec[SRC_TIMER2] = ctrl_one_q[TIMER2_CTRL_POS];

    // a word under suppression is not decoded, even if it is a skip itself
    assign exec_now = instr_in.valid && (state_q == SEQ_RUN);

    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            hit_vec[i] = exec_now
                && (instr_in.opcode == OPCODES[i]);
            // control bit set makes it a no-operation
            take_vec[i] = hit_vec[i] && !ctrl_vec[i]
                && flag_vec[i];
        end
    end

    assign any_take = |take_vec;

    // skip sequencing, one instruction cycle per valid word
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q     <= SEQ_RUN;
            skip_next_q <= 1'b0;
        end else if (instr_in.valid) begin
            unique case (state_q)
                SEQ_RUN: begin
                    if (any_take) begin
                        state_q     <= SEQ_SKIP;
                        skip_next_q <= 1'b1;
                    end
                end
                SEQ_SKIP: begin
                    // exactly one word is swallowed, pc still steps over it
                    state_q     <= SEQ_RUN;
                    skip_next_q <= 1'b0;
                end
            endcase
        end
    end

    // these instructions never write carry; tells the alu to hold it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            carry_hold_q <= 1'b0;
        end else begin
            carry_hold_q <= |hit_vec;
        end
    end

    // control registers and interrupt mask
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_one_q <= CTRL_RESET;
            ctrl_two_q <= CTRL_RESET;
            mask_q     <= MASK_RESET;
        end else if (wr_in) begin
            if (addr_in == ADDR_CTRL_ONE) begin
                ctrl_one_q <= wdata_in[3:0];
            end
            if (addr_in == ADDR_CTRL_TWO) begin
                ctrl_two_q <= wdata_in[3:0];
            end
            if (addr_in == ADDR_MASK) begin
                mask_q <= wdata_in[NUM_SRC-1:0];
            end
        end
    end

    // sticky skip-taken events, write one to clear, a new event wins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= STATUS_RESET;
        end else begin
            if (wr_in && addr_in == ADDR_STATUS) begin
                status_q <= (status_q & ~wdata_in[NUM_SRC-1:0]) | take_vec;
            end else begin
                status_q <= status_q | take_vec;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else if (rd_in) begin
            unique case (addr_in)
                ADDR_CTRL_ONE: rdata_q <= {4'h0, ctrl_one_q};
                ADDR_CTRL_TWO: rdata_q <= {4'h0, ctrl_two_q};
                ADDR_FLAGS:    rdata_q <= {5'h00, flag_vec};
                ADDR_STATUS:   rdata_q <= {5'h00, status_q};
                ADDR_MASK:     rdata_q <= {5'h00, mask_q};
                default:       rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_out      = rdata_q;
    assign flags_out      = flag_vec;
    assign skip_next_out  = skip_next_q;
    assign carry_hold_out = carry_hold_q;
    assign irq_out        = irq_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    serial_skip_taken_a: assert property (
        instr_in.valid && !skip_next_q && instr_in.opcode == OPC_SKIP_SERIAL
        && !ctrl_two_q[SERIAL_CTRL_POS] && flag_vec[SRC_SERIAL]
        |=> skip_next_q && status_q[SRC_SERIAL])
        else $error("serial skip not taken");

    serial_flag_clear_a: assert property (
        take_vec[SRC_SERIAL] && !set_vec[SRC_SERIAL]
        |=> !flag_vec[SRC_SERIAL])
        else $error("serial flag not cleared by skip");

    serial_nop_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_SERIAL
        && ctrl_two_q[SERIAL_CTRL_POS]
        |=> !skip_next_q && flag_vec[SRC_SERIAL]
            == ($past(flag_vec[SRC_SERIAL]) || $past(set_vec[SRC_SERIAL])))
        else $error("serial skip with control set not a no-op");

    timer1_skip_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER1
        && !ctrl_one_q[TIMER1_CTRL_POS] && flag_vec[SRC_TIMER1]
        && !set_vec[SRC_TIMER1]
        |=> skip_next_q && !flag_vec[SRC_TIMER1])
        else $error("timer 1 skip or clear missing");

    timer1_nop_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER1
        && (ctrl_one_q[TIMER1_CTRL_POS] || !flag_vec[SRC_TIMER1])
        |=> !skip_next_q)
        else $error("timer 1 skip taken wrongly");

    timer2_skip_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER2
        && !ctrl_one_q[TIMER2_CTRL_POS] && flag_vec[SRC_TIMER2]
        && !set_vec[SRC_TIMER2]
        |=> skip_next_q ##0 !flag_vec[SRC_TIMER2])
        else $error("timer 2 skip or clear missing");

    one_word_skip_a: assert property (
        skip_next_q && instr_in.valid |=> !skip_next_q)
        else $error("skip lasted beyond one word");

    carry_hold_a: assert property (
        exec_now && (instr_in.opcode == OPC_SKIP_TIMER2
        || instr_in.opcode == OPC_SKIP_TIMER1
        || instr_in.opcode == OPC_SKIP_SERIAL) |=> carry_hold_q)
        else $error("carry hold missing for skip instruction");

    irq_level_a: assert property (
        |(status_q & mask_q) |=> irq_q)
        else $error("interrupt output not raised");

    irq_low_a: assert property (
        !(|(status_q & mask_q)) |=> !irq_q)
        else $error("interrupt output raised without cause");

    timer1_keep_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER1
        && ctrl_one_q[TIMER1_CTRL_POS]
        |=> flag_vec[SRC_TIMER1]
            == ($past(flag_vec[SRC_TIMER1]) || $past(set_vec[SRC_TIMER1])))
        else $error("timer 1 flag changed by no-op skip");

    timer2_nop_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER2
        && ctrl_one_q[TIMER2_CTRL_POS]
        |=> !skip_next_q && flag_vec[SRC_TIMER2]
            == ($past(flag_vec[SRC_TIMER2]) || $past(set_vec[SRC_TIMER2])))
        else $error("timer 2 skip with control set not a no-op");

    serial_no_flag_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_SERIAL
        && !flag_vec[SRC_SERIAL]
        |=> !skip_next_q)
        else $error("serial skip taken with flag clear");

    timer2_no_flag_a: assert property (
        exec_now && instr_in.opcode == OPC_SKIP_TIMER2
        && !flag_vec[SRC_TIMER2]
        |=> !skip_next_q)
        else $error("timer 2 skip taken with flag clear");

    // no other word may touch the skip state or the carry
    foreign_op_a: assert property (
        exec_now && instr_in.opcode != OPC_SKIP_SERIAL
        && instr_in.opcode != OPC_SKIP_TIMER1
        && instr_in.opcode != OPC_SKIP_TIMER2
        |=> !skip_next_q && !carry_hold_q)
        else $error("foreign opcode acted as a skip");

    suppressed_word_a: assert property (
        skip_next_q && instr_in.valid
        |=> !carry_hold_q
            && flag_vec == ($past(flag_vec) | $past(set_vec)))
        else $error("suppressed word was decoded");

    skip_hold_a: assert property (
        skip_next_q && !instr_in.valid |=> skip_next_q)
        else $error("skip dropped before the next word");

    // a peripheral request in the clearing cycle must not be lost
    set_wins_a: assert property (
        |(take_vec & set_vec)
        |=> (flag_vec & $past(take_vec) & $past(set_vec))
            == ($past(take_vec) & $past(set_vec)))
        else $error("request lost in the clearing cycle");

    status_event_a: assert property (
        |take_vec |=> (status_q & $past(take_vec)) == $past(take_vec))
        else $error("skip event not recorded in status");

    status_clear_a: assert property (
        wr_in && addr_in == ADDR_STATUS && !(|take_vec)
        |=> (status_q & $past(wdata_in[NUM_SRC-1:0])) == '0)
        else $error("status bit not cleared by write of one");

    // read data must idle at zero so a bus mux can or it in
    rdata_idle_a: assert property (
        !rd_in |=> rdata_q == '0)
        else $error("read data outside the read cycle");

endmodule

/* File: bench/skip_flag_decoder_tb_top.sv */
// self-checking bench for the flag-skip instruction block
`timescale 1ns/1ps
module skip_flag_decoder_tb_top;
    import skip_flag_pkg::*;

    logic              clk_in;
    logic              rst_n_in;
    instr_t            instr;
    src_vec_t          request_set;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    src_vec_t          flags;
    logic              skip_next;
    logic              carry_hold;
    logic              irq;
    logic [2:0]        flag_bits;
    int                mismatches;
    int                check_count;
    logic [OPC_W-1:0]  op_tab [3];
    logic [ADDR_W-1:0] ctrl_addr [3];
    int                ctrl_pos [3];

    assign flag_bits = flags;

    skip_flag_decoder skip_flag_decoder_i (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .instr_in       (instr),
        .request_set_in (request_set),
        .addr_in        (addr),
        .wdata_in       (wdata),
        .wr_in          (wr),
        .rd_in          (rd),
        .rdata_out      (rdata),
        .flags_out      (flags),
        .skip_next_out  (skip_next),
        .carry_hold_out (carry_hold),
        .irq_out        (irq)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask

    task automatic exec(input logic [OPC_W-1:0] op);
        @(posedge clk_in);
        instr <= '{valid: 1'b1, opcode: op};
        @(posedge clk_in);
        instr.valid <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int s);
        @(posedge clk_in);
        request_set <= src_vec_t'(3'h1 << s);
        @(posedge clk_in);
        request_set <= '0;
        #1 chk("flag set", 8'h1, {7'h0, flag_bits[s]});
    endtask

    initial begin
        op_tab    = '{OPC_SKIP_SERIAL, OPC_SKIP_TIMER1, OPC_SKIP_TIMER2};
        ctrl_addr = '{ADDR_CTRL_TWO, ADDR_CTRL_ONE, ADDR_CTRL_ONE};
        ctrl_pos  = '{SERIAL_CTRL_POS, TIMER1_CTRL_POS, TIMER2_CTRL_POS};
        mismatches  = 0;
        check_count = 0;
        rst_n_in    = 1'b0;
        instr       = '0;
        request_set = '0;
        addr        = '0;
        wdata       = '0;
        wr          = 1'b0;
        rd          = 1'b0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            reg_rd(a[ADDR_W-1:0], 8'h0);
        end
        $display("test reset done");

        for (int s = 0; s < 3; s++) begin
            // control bit set: pure no-operation, flag kept
            reg_wr(ctrl_addr[s], 8'h1 << ctrl_pos[s]);
            pulse(s);
            exec(op_tab[s]);
            chk("nop skip", 8'h0, {7'h0, skip_next});
            chk("nop flag", 8'h1, {7'h0, flag_bits[s]});
            chk("nop carry", 8'h1, {7'h0, carry_hold});
            // control bit clear with flag set: skip and clear
            reg_wr(ctrl_addr[s], 8'h0);
            exec(op_tab[s]);
            chk("skip", 8'h1, {7'h0, skip_next});
            chk("cleared", 8'h0, {7'h0, flag_bits[s]});
            chk("carry hold", 8'h1, {7'h0, carry_hold});
            pulse(s);
            repeat (2) @(posedge clk_in);
            #1 chk("skip held", 8'h1, {7'h0, skip_next});
            // the suppressed word is a skip opcode: must not act
            exec(op_tab[s]);
            chk("suppressed", 8'h0, {7'h0, skip_next});
            chk("kept flag", 8'h1, {7'h0, flag_bits[s]});
            chk("no carry", 8'h0, {7'h0, carry_hold});
            exec(op_tab[s]);
            exec(10'h000);
            // flag now clear: next word runs
            exec(op_tab[s]);
            chk("no flag", 8'h0, {7'h0, skip_next});
            $display("test source %0d done", s);
        end

        // other opcodes never skip, even with all flags set
        for (int s = 0; s < 3; s++) begin
            pulse(s);
        end
        exec(10'h289);
        chk("foreign op", 8'h0, {7'h0, skip_next});
        chk("foreign flags", 8'h7, {5'h0, flag_bits});
        // request arriving while the skip clears it: the request wins
        @(posedge clk_in);
        request_set <= src_vec_t'(3'h2);
        instr       <= '{valid: 1'b1, opcode: OPC_SKIP_TIMER1};
        @(posedge clk_in);
        request_set <= '0;
        instr.valid <= 1'b0;
        #1 chk("set wins skip", 8'h1, {7'h0, skip_next});
        chk("set wins flag", 8'h7, {5'h0, flag_bits});
        exec(10'h000);
        chk("set wins done", 8'h0, {7'h0, skip_next});
        $display("test decode done");

        reg_rd(ADDR_STATUS, 8'h7);
        chk("irq masked", 8'h0, {7'h0, irq});
        reg_wr(ADDR_MASK, 8'h2);
        @(posedge clk_in);
        #1 chk("irq raised", 8'h1, {7'h0, irq});
        reg_wr(ADDR_STATUS, 8'h2);
        @(posedge clk_in);
        #1 chk("irq cleared", 8'h0, {7'h0, irq});
        reg_rd(ADDR_STATUS, 8'h5);
        reg_wr(3'h7, 8'hff);
        reg_rd(3'h7, 8'h0);
        reg_rd(ADDR_MASK, 8'h2);
        $display("test interrupt done");
        end_of_test();
    end

    initial begin
        #100us;
        mismatches++;
        end_of_test();
    end
endmodule
